// ===== dv/adphp_host_model.sv
// adphp_host_model: host side of the port, microprocessor or epp
// assumes: pins change at falling clock edges; released bus shows ~last
`timescale 1ns/1ps
module adphp_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] bus_pin,
  output logic            pd,
  output logic            cs_n,
  output logic            sa_n,
  output logic            sb,
  output logic            lp,
  output logic [2:0]      a,
  output logic [7:0]      bd
);
  logic [7:0] d = 8'h00;
  logic       en = 1'b0;
  logic       sep = 1'b1;
  assign bd = en ? d : ~d;
  // ==========================================================================
  // pin set-up and bus cycles
  task automatic setup(input bit s, input logic [2:0] st, input bit l);
    pd = 1'b1;
    sep = s;
    sb = s;
    a = st;
    lp = l;
    cs_n = 1'b0;
    sa_n = 1'b1;
  endtask
  task automatic power_cycle();
    repeat (4) @(negedge clock);
    pd = 1'b0;
  endtask
  // address phase only as a write: no address read cycles
  task automatic latch(input logic [5:0] ad, input bit epp);
    @(negedge clock);
    d = {2'h0, ad};
    en = 1'b1;
    lp = ~epp;
    repeat (4) @(negedge clock);
    lp = epp;
    repeat (2) @(negedge clock);
    en = 1'b0;
  endtask
  task automatic acc(input bit rd, input logic [7:0] wd,
                     output logic [7:0] q);
    @(negedge clock);
    d = wd;
    en = ~rd;
    if (sep) begin
      if (rd) sa_n = 1'b0;
      else sb = 1'b0;
    end else begin
      sb = rd;
      @(negedge clock);
      sa_n = 1'b0;
    end
    repeat (6) @(negedge clock);
    q = bus_pin;
    sa_n = 1'b1;
    sb = sep;
    repeat (6) @(negedge clock);
    en = 1'b0;
  endtask
endmodule // adphp_host_model

// ===== dv/adphp_monitor.sv
// adphp_monitor: port-level checks of the host port
// assumes: bound into adphp_host_port, one clock domain
`timescale 1ns/1ps
module adphp_monitor (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic [7:0]             bus_out,
  input wire logic                   bus_oe,
  input wire logic                   hold_off_out,
  input wire logic                   hold_off_oe,
  input wire adphp_pkg::adphp_mode_t mode,
  input wire logic                   internal_reset,
  input wire adphp_pkg::adphp_req_t  req,
  input wire logic [7:0]             core_rdata
);
  // ==========================================================================
  // checks
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_rd_drives: assert property (req.rd |-> bus_oe)
    else $error("read pulse without bus drive");
  chk_oe_cause: assert property ($rose(bus_oe) |-> req.rd)
    else $error("bus driven without a read");
  chk_rd_value: assert property (bus_oe |-> bus_out == core_rdata)
    else $error("read data differs from core data");
  chk_oe_stands: assert property ($rose(bus_oe) |-> bus_oe [*3])
    else $error("bus drive dropped early");
  chk_wr_quiet: assert property (req.wr |-> !bus_oe)
    else $error("bus driven during a write");
  chk_pd_quiet: assert property (
    internal_reset |-> !(req.wr || req.rd || bus_oe))
    else $error("activity during powerdown");
  chk_mode_clear: assert property (
    internal_reset && $past(internal_reset)
      |-> mode == adphp_pkg::ADPHP_MODE_NONE)
    else $error("mode kept through reset");
  chk_pulse_once: assert property (
    (req.wr || req.rd) |=> !(req.wr || req.rd))
    else $error("request pulse too long");
  chk_hold_epp: assert property (
    hold_off_oe |-> mode == adphp_pkg::ADPHP_MODE_EPP)
    else $error("hold-off driven outside epp");
  chk_epp_wait: assert property (
    mode == adphp_pkg::ADPHP_MODE_EPP && req.rd |-> !hold_off_out)
    else $error("hold-off high during access");
  chk_hold_first: assert property (
    $rose(hold_off_oe) |-> !hold_off_out)
    else $error("hold-off high at first address strobe");
endmodule // adphp_monitor

bind adphp_host_port adphp_monitor mon_u (
  .clock, .rst, .bus_out, .bus_oe, .hold_off_out, .hold_off_oe, .mode,
  .internal_reset, .req, .core_rdata
);

// ===== dv/tb_auto_detect_parallel_host_port.sv
// tb_auto_detect_parallel_host_port: self-checking bench for the port
// assumes: host model drives pins; core read data is a fixed address map
`timescale 1ns/1ps
module tb_auto_detect_parallel_host_port;
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic                   pd, cs_n, sa_n, sb, lp, bus_oe;
  logic                   hold_off_out, hold_off_oe, internal_reset;
  logic [2:0]             a, pins;
  logic [7:0]             bd, bus_out, bus, core_rdata, q;
  logic [15:0]            seed = 16'hcd86;
  int                     err_count = 0;
  int                     tests_run = 0;
  adphp_pkg::adphp_mode_t mode;
  adphp_pkg::adphp_req_t  req;
  adphp_pkg::adphp_req_t  exp_q[$];
  assign bus = bus_oe ? bus_out : bd;
  assign pins = {a[2:1], hold_off_oe ? hold_off_out : a[0]};
  assign core_rdata = {req.addr, 2'h1} ^ 8'ha5;
  initial forever #2.5 clock = ~clock;
  adphp_host_port dut_u (.clock, .rst, .reset_powerdown_in(pd),
    .chip_select_n(cs_n), .strobe_a_n(sa_n), .strobe_b(sb),
    .latch_pin(lp), .addr_pins_in(pins), .bus_in(bus), .bus_out,
    .bus_oe, .hold_off_out, .hold_off_oe, .mode, .internal_reset,
    .req, .core_rdata);
  adphp_host_model host_u (.clock, .bus_pin(bus), .pd, .cs_n, .sa_n,
    .sb, .lp, .a, .bd);
  // ==========================================================================
  // model, compare and close
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    if (!rst && (req.wr || req.rd)) begin
      if (exp_q.size() == 0) check(req, 16'h0000);
      else check({req.wr, req.rd, req.addr, req.wr ? req.wdata : 8'h00},
                 exp_q.pop_front());
    end
  end
  task automatic xfer(input logic [5:0] ad, input logic [7:0] wd);
    exp_q.push_back({2'h2, ad, wd});
    host_u.acc(1'b0, wd, q);
    exp_q.push_back({2'h1, ad, 8'h00});
    host_u.acc(1'b1, 8'h00, q);
    check(q, {ad, 2'h1} ^ 8'ha5);
  endtask
  task automatic run(input adphp_pkg::adphp_mode_t m);
    logic [5:0] ad;
    bit         sp, ded;
    seed = lfsr(seed);
    ad = seed[5:0];
    sp = m inside {adphp_pkg::ADPHP_MODE_SEP_DED, adphp_pkg::ADPHP_MODE_SEP_MUX};
    ded = m inside {adphp_pkg::ADPHP_MODE_SEP_DED,
                    adphp_pkg::ADPHP_MODE_COM_DED};
    // a2 = a1 = 1 with chip select low is the epp strap, so keep it out
    if (ded && ad[2:1] == 2'h3) ad[2] = 1'b0;
    host_u.setup(sp, ded ? ad[2:0] : sp ? adphp_pkg::STRAP_SEP_MUX
                 : adphp_pkg::STRAP_COM_MUX, ded);
    host_u.power_cycle();
    for (int n = 0; n < 60 && mode === adphp_pkg::ADPHP_MODE_NONE; n++)
      @(negedge clock);
    check(mode, m);
    if (ded) ad = {3'h0, ad[2:0]};
    else host_u.latch(ad, 1'b0);
    xfer(ad, seed[15:8]);
  endtask
  // ==========================================================================
  // sequence
  initial begin
    host_u.setup(1'b1, 3'h3, 1'b0);
    repeat (4) @(negedge clock);
    rst = 1'b0;
    check({bus_oe, hold_off_oe, hold_off_out, internal_reset, mode},
          7'h18);
    for (int i = 1; i < 5; i++) run(adphp_pkg::adphp_mode_t'(i));
    seed = lfsr(seed);
    host_u.setup(1'b0, 3'h7, 1'b1);
    host_u.power_cycle();
    repeat (10) @(negedge clock);
    check(hold_off_oe, 1'b0);
    host_u.latch(seed[5:0], 1'b1);
    check({mode, hold_off_oe}, {adphp_pkg::ADPHP_MODE_EPP, 1'b1});
    xfer(seed[5:0], seed[15:8]);
    check(hold_off_out, 1'b1);
    host_u.cs_n = 1'b1;
    host_u.acc(1'b0, 8'h3c, q);
    host_u.pd = 1'b1;
    host_u.cs_n = 1'b0;
    repeat (4) @(negedge clock);
    check(internal_reset, 1'b1);
    host_u.acc(1'b0, 8'hc3, q);
    close_out();
  end
  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule // tb_auto_detect_parallel_host_port

// ===== rtl/adphp_host_port.sv
// adphp_host_port: 8-bit parallel host port with bus style detection
// assumes: host pins are asynchronous and are synchronised here; core
// returns read data combinationally for the presented address
//
// Operation
// - dedicated bus: drive data only on reads
// - muxed bus: address on low six, then data
// - latch address while latch high and strobe inactive
// - epp: latch address while addr strobe low
// - epp hold-off low starts, high ends cycle
// - dedicated: three address pins give bits 0-2
// - powerdown high: ignore all bus activity
// - powerdown falling edge ends internal reset
// - epp only muxed, with hold-off output
// - after reset clear mode, detect afresh
// - style from strap levels after reset
// - strap decode of latch and address pins
// - epp: data strobe ignored while deselected
// - hold-off undriven until first addr strobe
`timescale 1ns/1ps

module adphp_host_port (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       reset_powerdown_in,
  input  wire logic                       chip_select_n,
  input  wire logic                       strobe_a_n,
  input  wire logic                       strobe_b,
  input  wire logic                       latch_pin,
  input  wire logic [2:0]                 addr_pins_in,
  input  wire logic [7:0]                 bus_in,
  output logic [7:0]                      bus_out,
  output logic                            bus_oe,
  output logic                            hold_off_out,
  output logic                            hold_off_oe,
  output adphp_pkg::adphp_mode_t          mode,
  output logic                            internal_reset,
  output adphp_pkg::adphp_req_t           req,
  input  wire logic [7:0]                 core_rdata
);

  // ==========================================================================
  // input synchronisers
  adphp_pkg::adphp_pins_t pins_raw;
  adphp_pkg::adphp_pins_t sync1;
  adphp_pkg::adphp_pins_t pins;
  logic                   pd_s1;
  logic                   pd;

  assign pins_raw = '{chip_select_n: chip_select_n, strobe_a_n: strobe_a_n,
                      strobe_b: strobe_b, latch_pin: latch_pin,
                      addr_pins: addr_pins_in, bus: bus_in};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      pins  <= '1;
      pd_s1 <= 1'b1;
      pd    <= 1'b1;
    end else begin
      sync1 <= pins_raw;
      pins  <= sync1;
      pd_s1 <= reset_powerdown_in;
      pd    <= pd_s1;
    end
  end

  // ==========================================================================
  // state
  typedef enum logic [1:0] {
    ADPHP_ST_DOWN,
    ADPHP_ST_DETECT,
    ADPHP_ST_RUN
  } adphp_state_t;

  adphp_state_t                      state;
  adphp_state_t                      next_state;
  adphp_pkg::adphp_mode_t            next_mode;
  logic [adphp_pkg::ADDR_W-1:0]      addr_reg;
  logic [adphp_pkg::ADDR_W-1:0]      next_addr_reg;
  logic                              strobe_d;
  logic                              next_strobe_d;
  logic                              latch_d;
  logic                              next_latch_d;
  logic                              hold_en;
  logic                              next_hold_en;
  logic                              hold_n;
  logic                              next_hold_n;
  logic [7:0]                        rdata;
  logic [7:0]                        next_rdata;
  logic                              drive;
  logic                              next_drive;
  adphp_pkg::adphp_req_t             next_req;
  logic                              pd_d;
  logic                              next_pd_d;
  logic                              pd_fall;
  logic                              was_read;
  logic                              next_was_read;

  // decoded per-mode controls
  logic muxed;
  logic epp;
  logic sel;
  logic strobe_act;
  logic is_read;
  logic latch_act;
  logic [adphp_pkg::ADDR_W-1:0] cur_addr;

  always_comb begin
    muxed = (mode == adphp_pkg::ADPHP_MODE_SEP_MUX) ||
            (mode == adphp_pkg::ADPHP_MODE_COM_MUX) ||
            (mode == adphp_pkg::ADPHP_MODE_EPP);
    epp   = (mode == adphp_pkg::ADPHP_MODE_EPP);
    sel   = !pins.chip_select_n;
    case (mode)
      adphp_pkg::ADPHP_MODE_SEP_DED,
      adphp_pkg::ADPHP_MODE_SEP_MUX: begin
        // either strobe low makes an access; read when read strobe low
        strobe_act = sel && (!pins.strobe_a_n || !pins.strobe_b);
        is_read    = !pins.strobe_a_n;
      end
      adphp_pkg::ADPHP_MODE_COM_DED,
      adphp_pkg::ADPHP_MODE_COM_MUX: begin
        strobe_act = sel && !pins.strobe_a_n;
        is_read    = pins.strobe_b;
      end
      adphp_pkg::ADPHP_MODE_EPP: begin
        strobe_act = sel && !pins.strobe_a_n;
        is_read    = pins.strobe_b;
      end
      default: begin
        strobe_act = 1'b0;
        is_read    = 1'b0;
      end
    endcase
    if (epp)
      latch_act = !pins.latch_pin;
    else
      latch_act = muxed && pins.latch_pin;
    if (muxed)
      cur_addr = addr_reg;
    else
      cur_addr = {3'h0, pins.addr_pins};
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_state    = state;
    next_mode     = mode;
    next_addr_reg = addr_reg;
    next_strobe_d = strobe_act;
    next_latch_d  = latch_act;
    next_rdata    = rdata;
    next_drive    = 1'b0;
    // the core reads combinationally, so the address stands at all times outside powerdown
    next_req      = '0;
    next_req.addr = cur_addr;
    case (state)
      ADPHP_ST_DOWN: begin
        next_mode    = adphp_pkg::ADPHP_MODE_NONE;
        next_addr_reg = adphp_pkg::ADDR_RESET;
        if (pd_fall)
          next_state = ADPHP_ST_DETECT;
      end
      ADPHP_ST_DETECT: begin
        next_state = ADPHP_ST_RUN;
        if (pins.latch_pin && !muxed &&
            pins.addr_pins[2:1] != adphp_pkg::STRAP_EPP_TOP)
          // latch tied high: dedicated bus, strobe style from idle level
          next_mode = pins.strobe_b ? adphp_pkg::ADPHP_MODE_SEP_DED
                                    : adphp_pkg::ADPHP_MODE_COM_DED;
        else if (pins.addr_pins == adphp_pkg::STRAP_SEP_MUX)
          next_mode = adphp_pkg::ADPHP_MODE_SEP_MUX;
        else if (pins.addr_pins == adphp_pkg::STRAP_COM_MUX)
          next_mode = adphp_pkg::ADPHP_MODE_COM_MUX;
        else if (pins.addr_pins[2:1] == adphp_pkg::STRAP_EPP_TOP &&
                 pins.chip_select_n == 1'b0)
          next_mode = adphp_pkg::ADPHP_MODE_EPP;
        else
          next_state = ADPHP_ST_DETECT;
      end
      ADPHP_ST_RUN: begin
        if (latch_act && !strobe_act)
          next_addr_reg = pins.bus[adphp_pkg::ADDR_W-1:0];
        if (strobe_act && is_read) begin
          next_rdata = core_rdata;
          next_drive = 1'b1;
        end
        if (strobe_act && !strobe_d) begin
          next_req.addr = cur_addr;
          next_req.rd   = is_read;
        end
        if (!strobe_act && strobe_d && !was_read) begin
          // write data taken at the strobe's trailing edge
          next_req.addr  = cur_addr;
          next_req.wr    = 1'b1;
          next_req.wdata = pins.bus;
        end
      end
      default: next_state = ADPHP_ST_DOWN;
    endcase
    if (pd) begin
      next_state = ADPHP_ST_DOWN;
      next_drive = 1'b0;
      next_req   = '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= ADPHP_ST_DOWN;
      mode     <= adphp_pkg::ADPHP_MODE_NONE;
      addr_reg <= adphp_pkg::ADDR_RESET;
      strobe_d <= 1'b0;
      latch_d  <= 1'b0;
      rdata    <= adphp_pkg::DATA_RESET;
      drive    <= 1'b0;
      req      <= '0;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      addr_reg <= next_addr_reg;
      strobe_d <= next_strobe_d;
      latch_d  <= next_latch_d;
      rdata    <= next_rdata;
      drive    <= next_drive;
      req      <= next_req;
    end
  end

  // ==========================================================================
  // access direction, kept so the trailing edge of a read is no write
  always_comb begin
    next_was_read = was_read;
    if (strobe_act)
      next_was_read = is_read;
    if (pd)
      next_was_read = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      was_read <= 1'b0;
    else
      was_read <= next_was_read;
  end

  // ==========================================================================
  // epp hold-off: undriven until the first address strobe after reset
  always_comb begin
    next_hold_en = hold_en;
    next_hold_n  = hold_n;
    if (state != ADPHP_ST_RUN) begin
      next_hold_en = 1'b0;
      next_hold_n  = 1'b1;
    end else if (epp) begin
      if (latch_act && !latch_d)
        next_hold_en = 1'b1;
      next_hold_n = !(strobe_act || latch_act);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_en <= 1'b0;
      hold_n  <= 1'b1;
    end else begin
      hold_en <= next_hold_en;
      hold_n  <= next_hold_n;
    end
  end

  // ==========================================================================
  // powerdown release; pd_d resets high so reset alone gives no edge
  assign pd_fall = pd_d && !pd;

  always_comb begin
    next_pd_d = pd;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      pd_d <= 1'b1;
    else
      pd_d <= next_pd_d;
  end

  // ==========================================================================
  // pin outputs
  assign bus_out        = rdata;
  assign bus_oe         = drive;
  assign hold_off_out   = hold_n;
  assign hold_off_oe    = hold_en && epp;
  assign internal_reset = (state == ADPHP_ST_DOWN);

endmodule // adphp_host_port

// ===== rtl/adphp_pkg.sv
// adphp_pkg: shared constants and carriers for the auto-detecting host port
// assumes: one 200 MHz clock; used as adphp_pkg::name, never imported
package adphp_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned PIN_ADDR_W = 3;

  // ==========================================================================
  // strap levels on the address pins: {a2, a1, a0}
  localparam logic [2:0] STRAP_SEP_MUX = 3'h3;
  localparam logic [2:0] STRAP_COM_MUX = 3'h2;
  localparam logic [1:0] STRAP_EPP_TOP = 2'h3;

  // ==========================================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ==========================================================================
  // bus styles
  typedef enum logic [2:0] {
    ADPHP_MODE_NONE,
    ADPHP_MODE_SEP_DED,
    ADPHP_MODE_SEP_MUX,
    ADPHP_MODE_COM_DED,
    ADPHP_MODE_COM_MUX,
    ADPHP_MODE_EPP
  } adphp_mode_t;

  // ==========================================================================
  // raw host pins, grouped
  typedef struct packed {
    logic             chip_select_n;
    logic             strobe_a_n;   // read strobe / shared / epp data strobe
    logic             strobe_b;     // write strobe / rw_direction / epp dir
    logic             latch_pin;    // ale / addr strobe / epp addr strobe
    logic [2:0]       addr_pins;    // a2..a0 (a0 doubles as hold-off out)
    logic [DATA_W-1:0] bus;
  } adphp_pins_t;

  // register-side access request toward the device core
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } adphp_req_t;

endpackage : adphp_pkg
